/* design/swd_window_ramp.v */
// timing reference window detector, tap capture and coarse delay ramp with its register port
`timescale 1ns/1ps
`include "swd_regs.vh"

// Function
// - with ramping on, move the applied coarse delay gradually toward the new code.
// - slow rate steps one code per 256 cycles, fast rate four per 256.
// - with ramp enabled, every coarse code write starts a fresh ramp.
// - single-channel mode samples on both clock edges.
// - find reference position against the clock edge, capture on a chosen tap.
// - measured reference position is held readable in the position flags.
// - flags are invalid until three reference rising edges were seen.
// - a flag is one for a risky tap, zero for a safe tap.
// - flags at taps 0 and 23 always read one.
// - select field holds the tap index; the reference is captured there.
// - 24 taps are reported, but selection reaches only taps 0 to 15.
// - fine-step control zero gives coarse tap spacing, one gives fine spacing.
// - every internal clock shifts with the programmed aperture delay.
module swd_window_ramp #(
	parameter TAPS = `SWD_TAPS,
	parameter CODE_W = 8
) (
	input wire clk,
	input wire reset,
	input wire [`SWD_ADDR_W-1:0] reg_addr,
	input wire [`SWD_DATA_W-1:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [`SWD_DATA_W-1:0] reg_rdata,
	input wire [TAPS-1:0] tap_sample,
	output reg [CODE_W-1:0] coarse_delay_code,
	output reg position_step_fine,
	output reg dual_edge_sample,
	output reg sysref_capture,
	output reg [3:0] capture_position_select
);

	////////////////////////////////////////////////////////////////////////////////
	// control registers

	reg [`SWD_DATA_W-1:0] clk_ctrl;
	reg [`SWD_DATA_W-1:0] ramp_ctrl;
	reg [CODE_W-1:0] coarse_written;
	wire coarse_write;
	wire ramp_enable_bit;
	wire ramp_speed_select;

	assign coarse_write = reg_write && (reg_addr == `SWD_ADDR_COARSE);
	assign ramp_enable_bit = ramp_ctrl[`SWD_RAMP_EN_BIT];
	assign ramp_speed_select = ramp_ctrl[`SWD_RAMP_FAST_BIT];

	// register writes; position flags and status are read only
	always @(posedge clk) begin
		if (reset) begin
			clk_ctrl <= `SWD_CLK_CTRL_RST;
			ramp_ctrl <= `SWD_RAMP_CTRL_RST;
			coarse_written <= `SWD_COARSE_RST;
		end else if (reg_write) begin
			case (reg_addr)
				`SWD_ADDR_CLK_CTRL: begin
					clk_ctrl <= reg_wdata;
				end
				`SWD_ADDR_RAMP_CTRL: begin
					ramp_ctrl <= reg_wdata;
				end
				`SWD_ADDR_COARSE: begin
					coarse_written <= reg_wdata[CODE_W-1:0];
				end
				default: begin
					clk_ctrl <= clk_ctrl;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// coarse delay ramp

	wire [CODE_W-1:0] coarse_now;
	wire ramp_busy;

	swd_delay_ramp #(
		.CODE_W(CODE_W)
	) u_ramp (
		.clk(clk),
		.reset(reset),
		.code_write(coarse_write),
		.code_target(reg_wdata[CODE_W-1:0]),
		.ramp_enable_bit(ramp_enable_bit),
		.ramp_speed_select(ramp_speed_select),
		.coarse_now(coarse_now),
		.ramp_busy(ramp_busy)
	);

	// delay code to the analog delay line, which moves every internal clock
	always @(posedge clk) begin
		if (reset) begin
			coarse_delay_code <= `SWD_COARSE_RST;
		end else begin
			coarse_delay_code <= coarse_now;
		end
	end

	// static clocking controls to the analog side
	always @(posedge clk) begin
		if (reset) begin
			position_step_fine <= 1'b0;
			dual_edge_sample <= 1'b0;
			capture_position_select <= 4'h0;
		end else begin
			position_step_fine <= clk_ctrl[`SWD_FINE_BIT];
			dual_edge_sample <= clk_ctrl[`SWD_SINGLE_BIT];
			capture_position_select <= clk_ctrl[`SWD_SEL_MSB:`SWD_SEL_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reference samples from the delayed clock taps

	wire [TAPS-1:0] tap_now;
	reg [TAPS-1:0] tap_prev;

	swd_sync2 #(
		.WIDTH(TAPS)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.async_in(tap_sample),
		.sync_out(tap_now)
	);

	// previous synchronised pattern for edge detection
	always @(posedge clk) begin
		if (reset) begin
			tap_prev <= {TAPS{1'b0}};
		end else begin
			tap_prev <= tap_now;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// position detector

	wire ref_rise;
	reg [TAPS-1:0] risky;
	reg [TAPS-1:0] pos_flags;
	reg [1:0] edge_cnt;
	reg fine_seen;
	integer i;

	// a reference rising edge: the largest delay tap has gone high
	assign ref_rise = tap_now[TAPS-1] & ~tap_prev[TAPS-1];

	// a tap next to a level change sits on the reference edge
	always @* begin
		risky = {TAPS{1'b0}};
		for (i = 0; i < TAPS - 1; i = i + 1) begin
			if (tap_now[i] != tap_now[i+1]) begin
				risky[i] = 1'b1;
				risky[i+1] = 1'b1;
			end
		end
		risky[`SWD_TAP_FIRST] = 1'b1;
		risky[`SWD_TAP_LAST] = 1'b1;
	end

	// flags refresh on every reference edge except in a step change cycle; step change restarts the count
	always @(posedge clk) begin
		if (reset) begin
			pos_flags <= {TAPS{1'b1}};
			edge_cnt <= 2'h0;
			fine_seen <= 1'b0;
		end else begin
			fine_seen <= clk_ctrl[`SWD_FINE_BIT];
			if (fine_seen != clk_ctrl[`SWD_FINE_BIT]) begin
				edge_cnt <= 2'h0; // spacing changed, old result stale
			end else if (ref_rise) begin
				pos_flags <= risky;
				if (edge_cnt != `SWD_EDGES_NEEDED) begin
					edge_cnt <= edge_cnt + 2'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// capture at the selected tap

	wire [3:0] sel;
	assign sel = clk_ctrl[`SWD_SEL_MSB:`SWD_SEL_LSB];

	// four select bits reach only taps 0 to 15
	always @(posedge clk) begin
		if (reset) begin
			sysref_capture <= 1'b0;
		end else begin
			sysref_capture <= tap_now[sel] & ~tap_prev[sel];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read port

	wire flags_valid;
	assign flags_valid = (edge_cnt == `SWD_EDGES_NEEDED);

	// read data registered one cycle after the read strobe
	always @(posedge clk) begin
		if (reset) begin
			reg_rdata <= {`SWD_DATA_W{1'b0}};
		end else if (reg_read) begin
			case (reg_addr)
				`SWD_ADDR_CLK_CTRL: begin
					reg_rdata <= clk_ctrl;
				end
				`SWD_ADDR_COARSE: begin
					reg_rdata <= coarse_written;
				end
				`SWD_ADDR_RAMP_CTRL: begin
					reg_rdata <= ramp_ctrl;
				end
				`SWD_ADDR_POS_LOW: begin
					reg_rdata <= pos_flags[7:0];
				end
				`SWD_ADDR_POS_MID: begin
					reg_rdata <= pos_flags[15:8];
				end
				`SWD_ADDR_POS_HIGH: begin
					reg_rdata <= pos_flags[23:16];
				end
				`SWD_ADDR_STATUS: begin
					reg_rdata <= {6'h00, ramp_busy, flags_valid};
				end
				`SWD_ADDR_COARSE_NOW: begin
					reg_rdata <= coarse_now;
				end
				default: begin
					reg_rdata <= {`SWD_DATA_W{1'b0}};
				end
			endcase
		end
	end

endmodule

/* design/swd_regs.vh */
// register map, field positions, reset values and timing figures of the window and ramp block
`ifndef SWD_REGS_VH
`define SWD_REGS_VH

// register port widths
`define SWD_ADDR_W 12
`define SWD_DATA_W 8

// register offsets
`define SWD_ADDR_CLK_CTRL 12'h029
`define SWD_ADDR_COARSE 12'h02a
`define SWD_ADDR_RAMP_CTRL 12'h02b
`define SWD_ADDR_POS_LOW 12'h02c
`define SWD_ADDR_POS_MID 12'h02d
`define SWD_ADDR_POS_HIGH 12'h02e
`define SWD_ADDR_STATUS 12'h02f
`define SWD_ADDR_COARSE_NOW 12'h030

// clock control fields
`define SWD_SEL_LSB 0
`define SWD_SEL_MSB 3
`define SWD_FINE_BIT 4
`define SWD_SINGLE_BIT 5

// ramp control fields
`define SWD_RAMP_EN_BIT 0
`define SWD_RAMP_FAST_BIT 1

// status fields
`define SWD_STAT_VALID_BIT 0
`define SWD_STAT_BUSY_BIT 1

// reset values
`define SWD_CLK_CTRL_RST 8'h00
`define SWD_COARSE_RST 8'h00
`define SWD_RAMP_CTRL_RST 8'h00

// tap geometry and reference edges needed before the flags are valid
`define SWD_TAPS 24
`define SWD_TAP_FIRST 0
`define SWD_TAP_LAST 23
`define SWD_EDGES_NEEDED 2'h3

// ramp timing: steps per period of device clock cycles
`define SWD_RAMP_PERIOD 256
`define SWD_RAMP_CNT_W 8
`define SWD_STEP_SLOW 8'h01
`define SWD_STEP_FAST 8'h04

`endif

/* design/swd_sync2.v */
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module swd_sync2 #(
	parameter WIDTH = 1
) (
	input wire clk,
	input wire reset,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always @(posedge clk) begin
		if (reset) begin
			meta <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule

/* design/swd_delay_ramp.v */
// coarse aperture delay ramp: walks the applied delay toward the written code
`timescale 1ns/1ps
`include "swd_regs.vh"
module swd_delay_ramp #(
	parameter CODE_W = 8
) (
	input wire clk,
	input wire reset,
	input wire code_write,
	input wire [CODE_W-1:0] code_target,
	input wire ramp_enable_bit,
	input wire ramp_speed_select,
	output reg [CODE_W-1:0] coarse_now,
	output reg ramp_busy
);

	reg [CODE_W-1:0] target;
	reg [`SWD_RAMP_CNT_W-1:0] period_cnt;
	reg [CODE_W-1:0] step;
	reg [CODE_W-1:0] gap;
	reg [CODE_W-1:0] next_coarse;

	// size of the next step, clipped so it never passes the target
	always @* begin
		step = ramp_speed_select ? `SWD_STEP_FAST : `SWD_STEP_SLOW;
		gap = (coarse_now > target) ? (coarse_now - target) : (target - coarse_now);
		if (gap < step) begin
			step = gap;
		end
		if (coarse_now > target) begin
			next_coarse = coarse_now - step;
		end else begin
			next_coarse = coarse_now + step;
		end
	end

	// ramp state: a write restarts the period, a step lands at the period end
	always @(posedge clk) begin
		if (reset) begin
			target <= `SWD_COARSE_RST;
			coarse_now <= `SWD_COARSE_RST;
			period_cnt <= {`SWD_RAMP_CNT_W{1'b0}};
			ramp_busy <= 1'b0;
		end else if (code_write) begin
			target <= code_target;
			period_cnt <= {`SWD_RAMP_CNT_W{1'b0}};
			if (ramp_enable_bit) begin
				ramp_busy <= (code_target != coarse_now);
			end else begin
				coarse_now <= code_target; // direct jump without ramp
				ramp_busy <= 1'b0;
			end
		end else if (ramp_busy) begin
			period_cnt <= period_cnt + 1'b1;
			if (period_cnt == `SWD_RAMP_PERIOD - 1) begin
				coarse_now <= next_coarse;
				ramp_busy <= (next_coarse != target);
			end
		end
	end

endmodule

/* testbench/swd_ref_source.sv */
// reference source model driving the delayed tap levels
`timescale 1ns/1ps
module swd_ref_source (
	input wire clk,
	input wire run,
	input wire [4:0] edge_tap,
	output reg [23:0] tap_sample
);
reg [3:0] cnt;
initial begin
	cnt = 4'h0;
	tap_sample = 24'h000000;
end
// one reference rise per 16 cycles, caught mid-transition by the taps
always @(posedge clk) begin
	if (!run) begin
		cnt <= 4'h0;
		tap_sample <= 24'h000000;
	end else begin
		cnt <= cnt + 4'h1;
		if (cnt == 4'h0)
			tap_sample <= ~((24'h000001 << edge_tap) - 24'h000001);
		if (cnt == 4'h2)
			tap_sample <= 24'hffffff;
		if (cnt == 4'h8)
			tap_sample <= 24'h000000;
	end
end
endmodule

/* testbench/swd_window_ramp_assertions.sv */
// port checker of the window and ramp block
`timescale 1ns/1ps
module swd_chk #(
	parameter TAPS = 24,
	parameter CODE_W = 8
) (
	input wire clk,
	input wire reset,
	input wire [11:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_rdata,
	input wire [TAPS-1:0] tap_sample,
	input wire [CODE_W-1:0] coarse_delay_code,
	input wire position_step_fine,
	input wire dual_edge_sample,
	input wire sysref_capture,
	input wire [3:0] capture_position_select
);
reg ramp_on;
reg [9:0] gap;
wire sel_bit = tap_sample[capture_position_select];
default clocking cb @(posedge clk); endclocking
default disable iff (reset);
// ramp enable mirror and cycles since the last code change
always @(posedge clk) begin
	if (reset) begin
		ramp_on <= 1'b0;
		gap <= 10'h000;
	end else begin
		if (reg_write && reg_addr == 12'h02b)
			ramp_on <= reg_wdata[0];
		if ((reg_write && reg_addr == 12'h02a) || $changed(coarse_delay_code))
			gap <= 10'h000;
		else if (gap != 10'h3ff)
			gap <= gap + 10'h001;
	end
end
////////////////////////////////////////////////////////////
property p_flag_low;
	reg_read && reg_addr == 12'h02c |=> reg_rdata[0];
endproperty
a_flag_low: assert property (p_flag_low) else $error("lowest tap flag clear");
property p_flag_high;
	reg_read && reg_addr == 12'h02e |=> reg_rdata[7];
endproperty
a_flag_high: assert property (p_flag_high) else $error("highest tap flag clear");
property p_unmapped;
	reg_read && reg_addr == 12'h000 |=> reg_rdata == 8'h00;
endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
property p_hold;
	!reg_read |=> $stable(reg_rdata);
endproperty
a_hold: assert property (p_hold) else $error("read data moved");
property p_ctrl;
	reg_write && reg_addr == 12'h029 |-> ##2
		{dual_edge_sample, position_step_fine, capture_position_select} == $past(reg_wdata[5:0], 2);
endproperty
a_ctrl: assert property (p_ctrl) else $error("control outputs wrong");
property p_pulse;
	sysref_capture |=> !sysref_capture;
endproperty
a_pulse: assert property (p_pulse) else $error("capture pulse too long");
property p_cap;
	sysref_capture |-> $past(sel_bit, 3) && !$past(sel_bit, 4);
endproperty
a_cap: assert property (p_cap) else $error("capture not at selected tap");
property p_step;
	ramp_on && $changed(coarse_delay_code) |-> CODE_W'(coarse_delay_code - $past(coarse_delay_code) + 4) <= 8;
endproperty
a_step: assert property (p_step) else $error("ramp step too large");
property p_gap;
	ramp_on && $changed(coarse_delay_code) |-> gap inside {[253:258]};
endproperty
a_gap: assert property (p_gap) else $error("ramp step spacing wrong");
endmodule
bind swd_window_ramp swd_chk #(.TAPS(TAPS), .CODE_W(CODE_W)) i_swd_chk (.clk(clk), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .tap_sample(tap_sample), .coarse_delay_code(coarse_delay_code),
	.position_step_fine(position_step_fine), .dual_edge_sample(dual_edge_sample),
	.sysref_capture(sysref_capture), .capture_position_select(capture_position_select));

/* testbench/swd_window_ramp_tb_top.sv */
// testbench of the window and ramp block
`timescale 1ns/1ps
module swd_window_ramp_tb_top;
reg clk = 1'b0;
reg reset;
reg [11:0] reg_addr;
reg [7:0] reg_wdata;
reg reg_write;
reg reg_read;
reg run;
reg [23:0] n;
wire [7:0] reg_rdata;
wire [23:0] tap_sample;
wire [7:0] coarse_delay_code;
wire position_step_fine;
wire dual_edge_sample;
wire sysref_capture;
wire [3:0] capture_position_select;
integer miscompares = 0;
integer check_count = 0;
always #20 clk = ~clk;
swd_window_ramp i_swd_window_ramp (.clk(clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.tap_sample(tap_sample), .coarse_delay_code(coarse_delay_code),
	.position_step_fine(position_step_fine), .dual_edge_sample(dual_edge_sample),
	.sysref_capture(sysref_capture), .capture_position_select(capture_position_select));
swd_ref_source i_swd_ref_source (.clk(clk), .run(run), .edge_tap(5'h0a), .tap_sample(tap_sample));
////////////////////////////////////////////////////////////
task check(input [23:0] seen, input [23:0] exp);
begin
	check_count = check_count + 1;
	if (seen !== exp) begin
		miscompares = miscompares + 1;
		$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
	end
end
endtask
task wr(input [11:0] a, input [7:0] d);
begin
	@(posedge clk);
	reg_write <= 1'b1;
	reg_addr <= a;
	reg_wdata <= d;
	@(posedge clk);
	reg_write <= 1'b0;
end
endtask
task rd(input [11:0] a, input [7:0] e);
begin
	@(posedge clk);
	reg_read <= 1'b1;
	reg_addr <= a;
	@(posedge clk);
	reg_read <= 1'b0;
	#1;
	check(reg_rdata, e);
end
endtask
task wt(input integer c);
begin
	repeat (c) @(posedge clk);
	#1;
end
endtask
// select a tap with the source paused, then count captures of three rises
// taps from the edge tap up rise with the reference, lower taps two cycles later,
// and a capture shows three cycles after its tap rises
task caps(input [3:0] s, input [23:0] f);
reg [23:0] k;
reg [23:0] first;
begin
	run <= 1'b0;
	wr(12'h029, {4'h1, s});
	run <= 1'b1;
	n = 24'h0;
	k = 24'h0;
	first = 24'h0;
	repeat (48) begin
		@(posedge clk);
		#1;
		k = k + 24'h1;
		if (sysref_capture === 1'b1) begin
			if (n == 24'h0)
				first = k;
			n = n + 24'h1;
		end
	end
	check(n, 24'h3);
	check(first, f);
end
endtask
task test_done;
begin
	$display("checks %0d, mismatches %0d", check_count, miscompares);
	if (miscompares == 0 && check_count > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
end
endtask
////////////////////////////////////////////////////////////
initial begin
	repeat (5000) @(posedge clk);
	miscompares = miscompares + 1;
	test_done;
end
initial begin
	reset <= 1'b1;
	reg_addr <= 12'h000;
	reg_wdata <= 8'h00;
	reg_write <= 1'b0;
	reg_read <= 1'b0;
	run <= 1'b0;
	repeat (4) @(posedge clk);
	reset <= 1'b0;
	rd(12'h029, 8'h00);
	rd(12'h02a, 8'h00);
	rd(12'h02b, 8'h00);
	rd(12'h02f, 8'h00);
	rd(12'h000, 8'h00);
	wr(12'h029, 8'h25);
	rd(12'h029, 8'h25);
	check({dual_edge_sample, position_step_fine, capture_position_select}, 6'h25);
	// position flags become valid on the third reference rise
	run <= 1'b1;
	wt(20);
	rd(12'h02f, 8'h00);
	wt(20);
	rd(12'h02f, 8'h01);
	rd(12'h02c, 8'h01);
	rd(12'h02d, 8'h06);
	rd(12'h02e, 8'h80);
	wr(12'h02c, 8'h00);
	rd(12'h02c, 8'h01);
	wr(12'h029, 8'h15);
	rd(12'h02f, 8'h00);
	wt(50);
	rd(12'h02f, 8'h01);
	caps(4'h0, 24'h6);
	caps(4'h5, 24'h6);
	caps(4'hc, 24'h4);
	caps(4'hf, 24'h4);
	// fast ramp walks to the target and clips the last step
	wr(12'h02b, 8'h03);
	wr(12'h02a, 8'h0a);
	rd(12'h02f, 8'h03);
	wt(256);
	check(coarse_delay_code, 8'h04);
	wt(256);
	check(coarse_delay_code, 8'h08);
	wt(256);
	check(coarse_delay_code, 8'h0a);
	rd(12'h02f, 8'h01);
	rd(12'h030, 8'h0a);
	wt(256);
	check(coarse_delay_code, 8'h0a);
	// slow ramp, restarted by a write in mid-ramp
	wr(12'h02b, 8'h01);
	wr(12'h02a, 8'h08);
	wt(258);
	check(coarse_delay_code, 8'h09);
	wr(12'h02a, 8'h0c);
	wt(254);
	check(coarse_delay_code, 8'h09);
	wt(4);
	check(coarse_delay_code, 8'h0a);
	rd(12'h02a, 8'h0c);
	wr(12'h02b, 8'h00);
	wr(12'h02a, 8'h40);
	wt(2);
	check(coarse_delay_code, 8'h40);
	test_done;
end
endmodule
